/* File: src/two_wire_slave_rx_tx.v */
// Two-wire bus slave receiver and transmitter with an APB register port.
`timescale 1ns/100ps
`include "two_wire_slave_defs.vh"
// Notes on behaviour
// - General-call data acked reports 90; next byte acked per ack_enable.
// - General-call data not acknowledged reports 98, then not addressed.
// - STOP or repeated START while addressed receiver reports A0.
// - Not addressed: own address if ack_enable, general call only if enabled.
// - Start request set at clear on leaving queues START until bus free.
// - Status codes assume prescaler bits zero; software masks them.
// - Upper seven own-address bits give the address answered.
// - Own-address bit 0 enables answering the general call address 00.
// - Address match then direction bit: one transmits, zero receives.
// - After address acknowledged, service flag set with valid status.
// - Arbitration lost then addressed for read reports B0.
// - Ack_enable cleared sends last byte; NACK gives C0, ACK gives C8.
// - After last byte device is not addressed; master reads all ones.
// - Ack_enable zero ignores own address yet keeps watching bus.
// - In deep sleep an address match is still acknowledged.
// - Match in sleep wakes chip, holds clock low until flag cleared.
// - After waking the data register need not hold the last bus byte.
// - Own address with read bit acknowledged reports A8.
// - Transmitted byte acknowledged reports B8; next byte last if ack off.
// - Transmitted byte not acknowledged reports C0, then not addressed.
module two_wire_slave_rx_tx (
  input  wire        clk_i,          // System clock, 40 MHz
  input  wire        rst_n_i,        // Asynchronous reset, active low
  input  wire        psel_i,         // APB select
  input  wire        penable_i,      // APB enable
  input  wire        pwrite_i,       // APB write
  input  wire [3:0]  paddr_i,        // APB byte address
  input  wire [31:0] pwdata_i,       // APB write data
  output reg         pready_o,       // APB ready
  output reg  [31:0] prdata_o,       // APB read data
  output reg         pslverr_o,      // APB error, unmapped address
  input  wire        scl_i,          // Serial clock line level
  output reg         scl_o,          // Serial clock drive value, always 0
  output reg         scl_oe_n_o,     // Serial clock enable, low drives
  input  wire        sda_i,          // Serial data line level
  output reg         sda_o,          // Serial data drive value, always 0
  output reg         sda_oe_n_o,     // Serial data enable, low drives
  input  wire        arb_lost_i,     // Master lost arbitration, level
  input  wire        sleep_i,        // Chip in a deep sleep state, level
  output reg         wake_o,         // Wake-up request, level
  output reg         start_launch_o  // Queued START handed out, pulse
);

  localparam S_IDLE = 4'd0;
  localparam S_ADDR = 4'd1;
  localparam S_AACK = 4'd2;
  localparam S_RXD  = 4'd3;
  localparam S_RACK = 4'd4;
  localparam S_TXD  = 4'd5;
  localparam S_TACK = 4'd6;
  localparam S_WAIT = 4'd7;

  localparam [7:0] CTL_RST = `RST_CONTROL;

  reg [2:0] scl_sy_r;
  reg [2:0] sda_sy_r;
  reg [3:0] state_r;
  reg [3:0] after_r;
  reg [3:0] cnt_r;
  reg [7:0] shift_r;
  reg [7:0] own_addr_r;
  reg [7:0] data_r;
  reg [7:0] status_r;
  reg [1:0] presc_r;
  reg       flag_r;
  reg       ack_en_r;
  reg       start_req_r;
  reg       stop_req_r;
  reg       wcol_r;
  reg       enable_r;
  reg       irq_en_r;
  reg       rw_r;
  reg       gc_r;
  reg       rx_addr_r;
  reg       ack_ret_r;
  reg       last_r;
  reg       mack_r;
  reg       leave_r;
  reg       start_pend_r;
  reg       bus_free_r;
  reg [7:0] rd_byte;

  wire scl_rise  = scl_sy_r[1] & ~scl_sy_r[2];
  wire scl_fall  = ~scl_sy_r[1] & scl_sy_r[2];
  wire start_det = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[1] & sda_sy_r[2];
  wire stop_det  = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[1] & ~sda_sy_r[2];
  wire sda_bit   = sda_sy_r[1];

  wire setup     = psel_i & ~penable_i;
  wire wr_done   = psel_i & penable_i & pready_o & pwrite_i;
  wire wr_ctl    = wr_done & (paddr_i == `OFS_CONTROL);
  wire wr_data   = wr_done & (paddr_i == `OFS_DATA);
  wire flag_clr  = wr_ctl & pwdata_i[`CTL_FLAG];

  // A frame addressed to us: own address, or general call when enabled.
  wire own_hit   = shift_r[7:1] == own_addr_r[7:1];
  wire gc_hit    = (shift_r[7:1] == `GEN_CALL_ADDR) & own_addr_r[0] &
                   ~shift_r[0];
  wire addr_hit  = enable_r & ack_en_r & (own_hit | gc_hit);

  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `OFS_OWN_ADDR) | (a == `OFS_CONTROL) |
               (a == `OFS_STATUS) | (a == `OFS_DATA);
    end
  endfunction

  always @* begin
    case (paddr_i)
      `OFS_OWN_ADDR: rd_byte = own_addr_r;
      `OFS_CONTROL:  rd_byte = {flag_r, ack_en_r, start_req_r, stop_req_r,
                               wcol_r, enable_r, 1'b0, irq_en_r};
      // The code sits above the prescaler so a mask recovers it.
      `OFS_STATUS:   rd_byte = {status_r[7:3], 1'b0, presc_r};
      `OFS_DATA:     rd_byte = data_r;
      default:       rd_byte = 8'h00;
    endcase
  end

  // APB slave: answers in the first access cycle.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped(paddr_i);
      if (setup) begin
        prdata_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_addr_r  <= `RST_OWN_ADDR;
      ack_en_r    <= CTL_RST[`CTL_ACK_EN];
      start_req_r <= 1'b0;
      stop_req_r  <= 1'b0;
      enable_r    <= 1'b0;
      irq_en_r    <= 1'b0;
      presc_r     <= `RST_PRESC;
    end else begin
      if (wr_done & (paddr_i == `OFS_OWN_ADDR)) begin
        own_addr_r <= pwdata_i[7:0];
      end
      if (wr_done & (paddr_i == `OFS_STATUS)) begin
        presc_r <= pwdata_i[1:0];
      end
      if (wr_ctl) begin
        ack_en_r    <= pwdata_i[`CTL_ACK_EN];
        start_req_r <= pwdata_i[`CTL_START_REQ];
        stop_req_r  <= pwdata_i[`CTL_STOP_REQ];
        enable_r    <= pwdata_i[`CTL_ENABLE];
        irq_en_r    <= pwdata_i[`CTL_IRQ_EN];
      end
    end
  end

  // Bus lines cross into the clock domain through two flops first.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sy_r <= 3'b111;
      sda_sy_r <= 3'b111;
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], scl_i};
      sda_sy_r <= {sda_sy_r[1:0], sda_i};
    end
  end

  // Serial engine. The flag set below always wins over a software clear,
  // because the engine only sets it outside S_WAIT and a clear acts there.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r      <= S_IDLE;
      after_r      <= S_IDLE;
      cnt_r        <= 4'h0;
      shift_r      <= 8'h00;
      data_r       <= `RST_DATA;
      status_r     <= `ST_NONE;
      flag_r       <= 1'b0;
      wcol_r       <= 1'b0;
      rw_r         <= 1'b0;
      gc_r         <= 1'b0;
      rx_addr_r    <= 1'b0;
      ack_ret_r    <= 1'b0;
      last_r       <= 1'b0;
      mack_r       <= 1'b0;
      leave_r      <= 1'b0;
      start_pend_r <= 1'b0;
      bus_free_r   <= 1'b1;
      wake_o       <= 1'b0;
      start_launch_o <= 1'b0;
      scl_o        <= 1'b0;
      sda_o        <= 1'b0;
      scl_oe_n_o   <= 1'b1;
      sda_oe_n_o   <= 1'b1;
    end else begin
      start_launch_o <= 1'b0;
      if (wr_data) begin
        if (flag_r) begin
          data_r <= pwdata_i[7:0];
          wcol_r <= 1'b0;
        end else begin
          wcol_r <= 1'b1;
        end
      end else if (wr_ctl) begin
        wcol_r <= pwdata_i[`CTL_WCOL] & wcol_r;
      end
      if (start_det) begin
        bus_free_r <= 1'b0;
      end else if (stop_det) begin
        bus_free_r <= 1'b1;
      end
      if (start_pend_r & bus_free_r) begin
        start_pend_r   <= 1'b0;
        start_launch_o <= 1'b1;
      end
      if (!enable_r) begin
        state_r    <= S_IDLE;
        flag_r     <= 1'b0;
        status_r   <= `ST_NONE;
        rx_addr_r  <= 1'b0;
        wake_o     <= 1'b0;
        scl_oe_n_o <= 1'b1;
        sda_oe_n_o <= 1'b1;
      end else if (state_r == S_WAIT) begin
        // Hold the clock low until software answers.
        scl_oe_n_o <= 1'b0;
        if (flag_clr) begin
          flag_r     <= 1'b0;
          status_r   <= `ST_NONE;
          wake_o     <= 1'b0;
          scl_oe_n_o <= 1'b1;
          state_r    <= after_r;
          cnt_r      <= 4'h0;
          ack_ret_r  <= pwdata_i[`CTL_ACK_EN];
          last_r     <= ~pwdata_i[`CTL_ACK_EN];
          if (leave_r & pwdata_i[`CTL_START_REQ]) begin
            start_pend_r <= 1'b1;
          end
          if (after_r == S_TXD) begin
            shift_r    <= {data_r[6:0], 1'b1};
            sda_oe_n_o <= data_r[7];
          end
        end
      end else if (start_det | stop_det) begin
        sda_oe_n_o <= 1'b1;
        state_r    <= start_det ? S_ADDR : S_IDLE;
        cnt_r      <= 4'h0;
        if (rx_addr_r) begin
          rx_addr_r <= 1'b0;
          flag_r    <= 1'b1;
          status_r  <= `ST_SR_STOP;
          leave_r   <= 1'b1;
          after_r   <= start_det ? S_ADDR : S_IDLE;
          state_r   <= S_WAIT;
        end
      end else begin
        case (state_r)
          S_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_bit};
              cnt_r   <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              if (addr_hit) begin
                sda_oe_n_o <= 1'b0;
                rw_r       <= shift_r[0];
                gc_r       <= gc_hit & ~own_hit;
                state_r    <= S_AACK;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              sda_oe_n_o <= 1'b1;
              flag_r     <= 1'b1;
              wake_o     <= sleep_i;
              leave_r    <= 1'b0;
              rx_addr_r  <= ~rw_r;
              state_r    <= S_WAIT;
              after_r    <= rw_r ? S_TXD : S_RXD;
              if (rw_r) begin
                status_r <= arb_lost_i ? `ST_ST_ADDR_AL
                                       : `ST_ST_ADDR;
              end else if (gc_r) begin
                status_r <= arb_lost_i ? `ST_SR_GC_AL : `ST_SR_GC;
              end else begin
                status_r <= arb_lost_i ? `ST_SR_ADDR_AL : `ST_SR_ADDR;
              end
            end
          end
          S_RXD: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_bit};
              cnt_r   <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              // A byte caught while asleep is not kept.
              if (!sleep_i) begin
                data_r <= shift_r;
              end
              sda_oe_n_o <= ~ack_ret_r;
              state_r    <= S_RACK;
            end
          end
          S_RACK: begin
            if (scl_fall) begin
              sda_oe_n_o <= 1'b1;
              flag_r     <= 1'b1;
              leave_r    <= ~ack_ret_r;
              rx_addr_r  <= ack_ret_r;
              state_r    <= S_WAIT;
              after_r    <= ack_ret_r ? S_RXD : S_IDLE;
              if (gc_r) begin
                status_r <= ack_ret_r ? `ST_GC_ACK
                                      : `ST_GC_NACK;
              end else begin
                status_r <= ack_ret_r ? `ST_SR_ACK : `ST_SR_NACK;
              end
            end
          end
          S_TXD: begin
            if (scl_fall) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7) begin
                sda_oe_n_o <= 1'b1;
                state_r    <= S_TACK;
              end else begin
                sda_oe_n_o <= shift_r[7];
                shift_r    <= {shift_r[6:0], 1'b1};
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_bit;
            end else if (scl_fall) begin
              flag_r  <= 1'b1;
              state_r <= S_WAIT;
              leave_r <= ~mack_r | last_r;
              // After the last byte the data line stays released.
              after_r <= (mack_r & ~last_r) ? S_TXD : S_IDLE;
              if (!mack_r) begin
                status_r <= `ST_ST_NACK;
              end else if (last_r) begin
                status_r <= `ST_ST_LAST;
              end else begin
                status_r <= `ST_ST_ACK;
              end
            end
          end
          default: begin
            state_r    <= S_IDLE;
            sda_oe_n_o <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // two_wire_slave_rx_tx

/* File: pkg/two_wire_slave_defs.vh */
// Constants for the two-wire slave: offsets, fields, reset values, codes.
`ifndef TWO_WIRE_SLAVE_DEFS_VH
`define TWO_WIRE_SLAVE_DEFS_VH

`define OFS_OWN_ADDR   4'h0
`define OFS_CONTROL    4'h4
`define OFS_STATUS     4'h8
`define OFS_DATA       4'hC

`define CTL_FLAG       7
`define CTL_ACK_EN     6
`define CTL_START_REQ  5
`define CTL_STOP_REQ   4
`define CTL_WCOL       3
`define CTL_ENABLE     2
`define CTL_IRQ_EN     0

`define RST_OWN_ADDR   8'h00
`define RST_CONTROL    8'h00
`define RST_DATA       8'hFF
`define RST_PRESC      2'h0

`define ST_NONE        8'hF8
`define ST_SR_ADDR     8'h60
`define ST_SR_ADDR_AL  8'h68
`define ST_SR_GC       8'h70
`define ST_SR_GC_AL    8'h78
`define ST_SR_ACK      8'h80
`define ST_SR_NACK     8'h88
`define ST_GC_ACK      8'h90
`define ST_GC_NACK     8'h98
`define ST_SR_STOP     8'hA0
`define ST_ST_ADDR     8'hA8
`define ST_ST_ADDR_AL  8'hB0
`define ST_ST_ACK      8'hB8
`define ST_ST_NACK     8'hC0
`define ST_ST_LAST     8'hC8

`define GEN_CALL_ADDR  7'h00

`endif

/* File: tb/two_wire_slave_rx_tx_monitor.sv */
// Checker for the two-wire slave's APB port and link pins.
`timescale 1ns/100ps
module two_wire_slave_rx_tx_monitor (
  input wire        clk_i,         // Clock
  input wire        rst_n_i,       // Reset, active low
  input wire        psel_i,        // Select
  input wire        penable_i,     // Enable
  input wire        pwrite_i,      // Write
  input wire [3:0]  paddr_i,       // Address
  input wire [31:0] pwdata_i,      // Write data
  input wire        pready_o,      // Ready
  input wire [31:0] prdata_o,      // Read data
  input wire        pslverr_o,     // Error
  input wire        scl_o,         // Clock drive value
  input wire        scl_oe_n_o,    // Clock enable, low drives
  input wire        sda_o,         // Data drive value
  input wire        wake_o,        // Wake request
  input wire        start_launch_o // START launch pulse
);
  // Only a flag clear or a disable may end a stretch or a wake request.
  wire clr = psel_i & penable_i & pready_o & pwrite_i &
             (paddr_i == 4'h4) & (pwdata_i[7] | ~pwdata_i[2]);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence ready_s; pready_o ##1 !pready_o; endsequence
  AST_APB_ANSWER: assert property (setup_s |=> ready_s)
    else $error("ready did not follow setup for one cycle");
  AST_ERR_MAP: assert property (
    pready_o |-> pslverr_o == (paddr_i[1:0] != 2'h0))
    else $error("error flag does not match the address map");
  AST_BYTE_WIDE: assert property (
    pready_o |-> prdata_o[31:8] == 24'h00_0000)
    else $error("read data above the byte is not zero");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("a line is driven high");
  AST_STRETCH_END: assert property (
    $rose(scl_oe_n_o) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("clock released without a flag clear");
  AST_WAKE_HOLD: assert property (
    $fell(wake_o) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("wake request dropped without a flag clear");
  AST_LAUNCH_PULSE: assert property (
    start_launch_o |=> !start_launch_o)
    else $error("start launch longer than one cycle");
  AST_LAUNCH_FREE: assert property (start_launch_o |-> scl_oe_n_o)
    else $error("start launched while stretching");
endmodule // two_wire_slave_rx_tx_monitor

bind two_wire_slave_rx_tx two_wire_slave_rx_tx_monitor u_mon (.*);

/* File: tb/two_wire_master_model.sv */
// Behavioural two-wire bus master standing on the far side of the link.
`timescale 1ns/100ps
module two_wire_master_model (
  input  wire clk_i,   // System clock, paces the link
  input  wire scl_w_i, // Resolved clock line
  input  wire sda_w_i, // Resolved data line
  output reg  scl_m_o, // Clock drive, one releases to the pull-up
  output reg  sda_m_o  // Data drive, one releases to the pull-up
);
  initial begin
    scl_m_o = 1'b1;
    sda_m_o = 1'b1;
  end
  // Four clocks a phase make the 200 ns link period.
  task automatic half;
    repeat (4) @(posedge clk_i);
  endtask
  // Data moves two clocks after the clock falls, so no false START is seen.
  task automatic lag;
    repeat (2) @(posedge clk_i);
  endtask
  // A stretched clock is waited out; the bench watchdog ends a stuck wait.
  task automatic rise;
    scl_m_o <= 1'b1;
    @(posedge clk_i);
    while (scl_w_i !== 1'b1) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic xbit(input logic b, output logic r);
    lag();
    sda_m_o <= b;
    lag();
    rise();
    r = sda_w_i;
    scl_m_o <= 1'b0;
  endtask
  task automatic start_c;
    lag();
    sda_m_o <= 1'b1;
    rise();
    sda_m_o <= 1'b0;
    half();
    scl_m_o <= 1'b0;
  endtask
  task automatic stop_c;
    lag();
    sda_m_o <= 1'b0;
    half();
    rise();
    sda_m_o <= 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ain,
                      output logic [7:0] q, output logic aout);
    integer i;
    for (i = 7; i >= 0; i = i - 1) xbit(d[i], q[i]);
    xbit(ain, aout);
  endtask
endmodule // two_wire_master_model

/* File: tb/two_wire_slave_rx_tx_tb.sv */
// Bench for the two-wire slave: APB software side and a link master.
`timescale 1ns/100ps
`include "two_wire_slave_defs.vh"
module two_wire_slave_rx_tx_tb;
  localparam [3:0] ct_a = `OFS_CONTROL;
  localparam [3:0] st_a = `OFS_STATUS;
  localparam [3:0] dt_a = `OFS_DATA;
  logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
  logic        arb_lost_i, sleep_i, scl_m, sda_m, a, err;
  logic [3:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, scl_o, scl_oe_n_o, sda_o;
  logic        sda_oe_n_o, wake_o, start_launch_o;
  logic [7:0]  q, d;
  logic [6:0]  own;
  logic [7:0]  exp_q [$];
  wire         scl_i = scl_m & (scl_oe_n_o | scl_o);
  wire         sda_i = sda_m & (sda_oe_n_o | sda_o);
  integer      fail_count = 0, compares = 0, launches = 0, seed = 37, i;
  two_wire_slave_rx_tx uut (.*);
  two_wire_master_model m (.clk_i(clk_i), .scl_w_i(scl_i),
    .sda_w_i(sda_i), .scl_m_o(scl_m), .sda_m_o(sda_m));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (start_launch_o === 1'b1) begin
      launches <= launches + 1;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] ad,
                     input logic [7:0] wd, output logic [31:0] r);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= {24'h00_0000, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    apb(1'b1, ad, v, rd);
  endtask
  task automatic rchk(input logic [3:0] ad, input logic [7:0] e);
    apb(1'b0, ad, 8'h00, rd);
    check(rd, {24'h00_0000, e});
  endtask
  // The device reacts about three clocks after a clock edge on the link.
  task automatic xf(input logic [7:0] v, input logic ain);
    m.xfer(v, ain, q, a);
    repeat (6) @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fail_count = fail_count + 1;
    final_report();
  end
  initial begin
    {psel_i, penable_i, pwrite_i, arb_lost_i, sleep_i, rst_n_i} = 6'h00;
    paddr_i = 4'h0;
    pwdata_i = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rchk(st_a, `ST_NONE);
    rchk(dt_a, `RST_DATA);
    rchk(ct_a, `RST_CONTROL);
    apb(1'b0, 4'h2, 8'h00, rd);
    check({31'h0000_0000, err}, 32'h0000_0001);
    own = 7'h01 + 7'({$random(seed)} % 126);
    wr(`OFS_OWN_ADDR, {own, 1'b1});
    rchk(`OFS_OWN_ADDR, {own, 1'b1});
    wr(dt_a, 8'h5A);
    rchk(ct_a, 8'h08);
    rchk(dt_a, `RST_DATA);
    wr(st_a, 8'h03);
    rchk(st_a, 8'hFB);
    wr(st_a, 8'h00);
    wr(ct_a, 8'h44);
    rchk(ct_a, 8'h44);
    $display("test registers done");
    m.start_c();
    xf({own, 1'b1}, 1'b1);
    check(a, 1'b0);
    rchk(st_a, `ST_ST_ADDR);
    for (i = 0; i < 2; i = i + 1) begin
      d = 8'($random(seed));
      exp_q.push_back(d);
      wr(dt_a, d);
      wr(ct_a, i ? 8'h84 : 8'hC4);
      xf(8'hFF, 1'b0);
      check(q, exp_q.pop_front());
      rchk(st_a, i ? `ST_ST_LAST : `ST_ST_ACK);
    end
    wr(ct_a, 8'hE4);
    xf(8'hFF, 1'b0);
    check(q, 8'hFF);
    m.stop_c();
    repeat (8) @(posedge clk_i);
    check(launches, 1);
    $display("test transmit done");
    arb_lost_i <= 1'b1;
    m.start_c();
    xf({own, 1'b1}, 1'b1);
    rchk(st_a, `ST_ST_ADDR_AL);
    arb_lost_i <= 1'b0;
    d = 8'($random(seed));
    wr(dt_a, d);
    wr(ct_a, 8'hC4);
    xf(8'hFF, 1'b1);
    check(q, d);
    rchk(st_a, `ST_ST_NACK);
    wr(ct_a, 8'hC4);
    m.stop_c();
    $display("test arbitration done");
    m.start_c();
    xf(8'h00, 1'b1);
    check(a, 1'b0);
    rchk(st_a, `ST_SR_GC);
    for (i = 0; i < 2; i = i + 1) begin
      wr(ct_a, i ? 8'h84 : 8'hC4);
      d = 8'($random(seed));
      xf(d, 1'b1);
      check(a, i);
      rchk(st_a, i ? `ST_GC_NACK : `ST_GC_ACK);
      rchk(dt_a, d);
    end
    wr(ct_a, 8'hC4);
    m.stop_c();
    rchk(st_a, `ST_NONE);
    $display("test general call done");
    wr(ct_a, 8'h04);
    m.start_c();
    xf({own, 1'b1}, 1'b1);
    check(a, 1'b1);
    m.stop_c();
    wr(`OFS_OWN_ADDR, {own, 1'b0});
    wr(ct_a, 8'h44);
    m.start_c();
    xf(8'h00, 1'b1);
    check(a, 1'b1);
    m.stop_c();
    rchk(st_a, `ST_NONE);
    $display("test isolation done");
    sleep_i <= 1'b1;
    m.start_c();
    xf({own, 1'b0}, 1'b1);
    check(a, 1'b0);
    check(wake_o, 1'b1);
    rchk(st_a, `ST_SR_ADDR);
    check(scl_oe_n_o, 1'b0);
    sleep_i <= 1'b0;
    wr(ct_a, 8'hC4);
    @(posedge clk_i);
    check(wake_o, 1'b0);
    xf(8'($random(seed)), 1'b1);
    rchk(st_a, `ST_SR_ACK);
    wr(ct_a, 8'hC4);
    m.stop_c();
    repeat (6) @(posedge clk_i);
    rchk(st_a, `ST_SR_STOP);
    wr(ct_a, 8'hC4);
    $display("test sleep and stop done");
    final_report();
  end
endmodule // two_wire_slave_rx_tx_tb
